// File: verilog/idb_consts.vh
`ifndef IDB_CONSTS_VH
`define IDB_CONSTS_VH

// ------------------------------------------------------------------
// control register byte offsets
// ------------------------------------------------------------------
`define IDB_OFF_CFG      11'h000
`define IDB_OFF_DEFCYL   11'h004
`define IDB_OFF_DEFHEAD  11'h008
`define IDB_OFF_DEFSPT   11'h00C
`define IDB_OFF_TOTAL    11'h010
`define IDB_OFF_CURCYL   11'h014
`define IDB_OFF_CURHEAD  11'h018
`define IDB_OFF_CURSPT   11'h01C
`define IDB_OFF_MULT     11'h020
`define IDB_OFF_CAPS     11'h024
`define IDB_OFF_XFER     11'h028
`define IDB_OFF_LONG     11'h02C
`define IDB_OFF_STAT     11'h030
`define IDB_OFF_CAPSECT  11'h034

// ------------------------------------------------------------------
// windows: string store and identify image
// ------------------------------------------------------------------
`define IDB_STR_PAGE     3'h1
`define IDB_STR_WORDS    6'h22
`define IDB_ID_PAGE      1'h1

// ------------------------------------------------------------------
// identify word numbers
// ------------------------------------------------------------------
`define IDB_W_CFG        8'h00
`define IDB_W_CYL        8'h01
`define IDB_W_HEAD       8'h03
`define IDB_W_SPT        8'h06
`define IDB_W_SER_LO     8'h0A
`define IDB_W_SER_HI     8'h13
`define IDB_W_LONG       8'h16
`define IDB_W_FW_LO      8'h17
`define IDB_W_FW_HI      8'h1A
`define IDB_W_MOD_LO     8'h1B
`define IDB_W_MOD_HI     8'h2E
`define IDB_W_MULT       8'h2F
`define IDB_W_CAPS       8'h31
`define IDB_W_PIO        8'h33
`define IDB_W_VALID      8'h35
`define IDB_W_CCYL       8'h36
`define IDB_W_CHEAD      8'h37
`define IDB_W_CSPT       8'h38
`define IDB_W_CAP_LO     8'h39
`define IDB_W_CAP_HI     8'h3A
`define IDB_W_MSET       8'h3B
`define IDB_W_TOT_LO     8'h3C
`define IDB_W_TOT_HI     8'h3D
`define IDB_W_DMA        8'h3F
`define IDB_W_APIO       8'h40

// ------------------------------------------------------------------
// string store slots
// ------------------------------------------------------------------
`define IDB_SLOT_FW      6'h0A
`define IDB_SLOT_MOD     6'h0E

// ------------------------------------------------------------------
// values
// ------------------------------------------------------------------
`define IDB_BIG_LIMIT    32'h00FC0000
`define IDB_BIG_CYL      16'h3FFF
`define IDB_BIG_HEAD     16'h0010
`define IDB_BIG_SPT      16'h003F
`define IDB_SPACES       16'h2020
`define IDB_RST_LONG     16'h0004
`define IDB_PIO_MAX      2'h2
`define IDB_DMA_ONE      8'h01
`define IDB_CFG_B15      16'h7FFF

`endif

// File: verilog/idb_identify_block.v
// Decided for this implementation: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`include "idb_consts.vh"

module idb_identify_block #(
  parameter ADDR_W = 11
) (
  input  wire              clk,
  input  wire              srst,
  input  wire [ADDR_W-1:0] address,
  input  wire              read,
  input  wire              write,
  input  wire [3:0]        byteenable,
  input  wire [31:0]       writedata,
  output reg  [31:0]       readdata,
  output wire              waitrequest
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  reg [15:0] genCfg_reg;
  reg [15:0] defCyl_reg;
  reg [15:0] defHead_reg;
  reg [15:0] defSpt_reg;
  reg [31:0] totalSect_reg;
  reg [15:0] curCyl_reg;
  reg [15:0] curHead_reg;
  reg [15:0] curSpt_reg;
  reg [7:0]  multMax_reg;
  reg [7:0]  multCur_reg;
  reg        multValid_reg;
  reg        standby_reg;
  reg        iordy_reg;
  reg        iordyOff_reg;
  reg        geomValid_reg;
  reg        extValid_reg;
  reg [1:0]  pioBasic_reg;
  reg [1:0]  pioAdv_reg;
  reg [7:0]  dmaSup_reg;
  reg [2:0]  dmaAct_reg;
  reg [15:0] longCnt_reg;
  reg        rdPend_reg;
  reg [15:0] strMem [0:`IDB_STR_WORDS-1];

  reg [31:0] rdNext;
  reg [15:0] idWordVal;
  reg [5:0]  strIdx;
  reg [7:0]  strOff;
  integer    i;

  // ------------------------------------------------------------------
  // byte-lane merge
  // ------------------------------------------------------------------
  function [31:0] mrg;
    input [31:0] old;
    input [31:0] dat;
    input [3:0]  be;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        mrg[k*8 +: 8] = be[k] ? dat[k*8 +: 8] : old[k*8 +: 8];
      end
    end
  endfunction

  // ------------------------------------------------------------------
  // byte-lane merge, half word
  // ------------------------------------------------------------------
  function [15:0] mrg16;
    input [15:0] old;
    input [15:0] dat;
    input [1:0]  be;
    integer k;
    begin
      for (k = 0; k < 2; k = k + 1) begin
        mrg16[k*8 +: 8] = be[k] ? dat[k*8 +: 8] : old[k*8 +: 8];
      end
    end
  endfunction

  // ------------------------------------------------------------------
  // derived identify fields
  // ------------------------------------------------------------------
  wire        bigCap   = totalSect_reg > `IDB_BIG_LIMIT;
  wire [47:0] capFull  = curCyl_reg * curHead_reg * curSpt_reg;
  wire [31:0] capSect  = capFull[31:0];
  wire        dmaHigh  = |dmaSup_reg[7:1];
  wire        iordyRep = iordy_reg | pioAdv_reg[0];
  wire        extRep   = extValid_reg | (|pioAdv_reg) | dmaHigh;
  wire [1:0]  pioRep   = (pioBasic_reg > `IDB_PIO_MAX) ? 2'h0 : pioBasic_reg;
  wire [7:0]  dmaHot   = `IDB_DMA_ONE << dmaAct_reg;
  wire        multOk   = |multMax_reg;

  wire [7:0]  idWord   = address[9:2];
  wire        idSel    = address[10] == `IDB_ID_PAGE;
  wire        strSel   = (address[10:8] == `IDB_STR_PAGE) &&
                         (address[7:2] < `IDB_STR_WORDS);

  // ------------------------------------------------------------------
  // identify image
  // ------------------------------------------------------------------
  always @* begin
    strOff = 8'h00;
    if (idWord >= `IDB_W_SER_LO && idWord <= `IDB_W_SER_HI) begin
      strOff = idWord - `IDB_W_SER_LO;
    end else if (idWord >= `IDB_W_FW_LO && idWord <= `IDB_W_FW_HI) begin
      strOff = idWord - `IDB_W_FW_LO + {2'b00, `IDB_SLOT_FW};
    end else if (idWord >= `IDB_W_MOD_LO && idWord <= `IDB_W_MOD_HI) begin
      strOff = idWord - `IDB_W_MOD_LO + {2'b00, `IDB_SLOT_MOD};
    end
    strIdx = strOff[5:0];
  end

  always @* begin
    idWordVal = 16'h0000;
    case (idWord)
      `IDB_W_CFG:    idWordVal = genCfg_reg & `IDB_CFG_B15;
      `IDB_W_CYL:    idWordVal = bigCap ? `IDB_BIG_CYL : defCyl_reg;
      `IDB_W_HEAD:   idWordVal = bigCap ? `IDB_BIG_HEAD : defHead_reg;
      `IDB_W_SPT:    idWordVal = bigCap ? `IDB_BIG_SPT : defSpt_reg;
      `IDB_W_LONG:   idWordVal = longCnt_reg;
      `IDB_W_MULT:   idWordVal = {8'h00, multMax_reg};
      `IDB_W_CAPS:   idWordVal = {2'b00, standby_reg, 1'b0, iordyRep,
                                  iordyOff_reg, 10'h000};
      `IDB_W_PIO:    idWordVal = {6'h00, pioRep, 8'h00};
      `IDB_W_VALID:  idWordVal = {14'h0000, extRep, geomValid_reg};
      `IDB_W_CCYL:   idWordVal = curCyl_reg;
      `IDB_W_CHEAD:  idWordVal = curHead_reg;
      `IDB_W_CSPT:   idWordVal = curSpt_reg;
      `IDB_W_CAP_LO: idWordVal = capSect[15:0];
      `IDB_W_CAP_HI: idWordVal = capSect[31:16];
      `IDB_W_MSET:   idWordVal = multOk ? {7'h00, multValid_reg, multCur_reg}
                                        : 16'h0000;
      `IDB_W_TOT_LO: idWordVal = totalSect_reg[15:0];
      `IDB_W_TOT_HI: idWordVal = totalSect_reg[31:16];
      `IDB_W_DMA:    idWordVal = {dmaHot, dmaSup_reg};
      `IDB_W_APIO:   idWordVal = {14'h0000, pioAdv_reg};
      default: begin
        if (strIdx != 6'h00 || idWord == `IDB_W_SER_LO) begin
          idWordVal = strMem[strIdx];
        end
      end
    endcase
  end

  // ------------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------------
  always @* begin
    rdNext = 32'h00000000;
    if (idSel) begin
      rdNext = {16'h0000, idWordVal};
    end else if (strSel) begin
      rdNext = {16'h0000, strMem[address[7:2]]};
    end else begin
      case (address)
        `IDB_OFF_CFG:     rdNext = {16'h0000, genCfg_reg};
        `IDB_OFF_DEFCYL:  rdNext = {16'h0000, defCyl_reg};
        `IDB_OFF_DEFHEAD: rdNext = {16'h0000, defHead_reg};
        `IDB_OFF_DEFSPT:  rdNext = {16'h0000, defSpt_reg};
        `IDB_OFF_TOTAL:   rdNext = totalSect_reg;
        `IDB_OFF_CURCYL:  rdNext = {16'h0000, curCyl_reg};
        `IDB_OFF_CURHEAD: rdNext = {16'h0000, curHead_reg};
        `IDB_OFF_CURSPT:  rdNext = {16'h0000, curSpt_reg};
        `IDB_OFF_MULT:    rdNext = {15'h0000, multValid_reg, multCur_reg, multMax_reg};
        `IDB_OFF_CAPS:    rdNext = {27'h0000000, extValid_reg, geomValid_reg,
                                    iordyOff_reg, iordy_reg, standby_reg};
        `IDB_OFF_XFER:    rdNext = {5'h00, dmaAct_reg, dmaSup_reg, 6'h00,
                                    pioAdv_reg, 6'h00, pioBasic_reg};
        `IDB_OFF_LONG:    rdNext = {16'h0000, longCnt_reg};
        `IDB_OFF_STAT:    rdNext = {28'h0000000, (longCnt_reg != `IDB_RST_LONG),
                                    iordyRep, extRep, bigCap};
        `IDB_OFF_CAPSECT: rdNext = capSect;
        default:          rdNext = 32'h00000000;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // bus handshake: reads wait one cycle, writes complete at once
  // ------------------------------------------------------------------
  assign waitrequest = read & ~rdPend_reg;

  always @(posedge clk) begin
    if (srst) begin
      rdPend_reg <= 1'b0;
      readdata   <= 32'h00000000;
    end else begin
      rdPend_reg <= read & ~rdPend_reg;
      if (read & ~rdPend_reg) begin
        readdata <= rdNext;
      end
    end
  end

  // ------------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------------
  wire [31:0] wd = writedata;
  wire [3:0]  be = byteenable;
  wire        wrCtl = write & ~idSel & ~strSel;

  // ------------------------------------------------------------------
  // default geometry, configuration and total sector count
  // ------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      genCfg_reg <= 16'h0000;
    end else if (wrCtl && address == `IDB_OFF_CFG) begin
      genCfg_reg <= mrg16(genCfg_reg, wd[15:0], be[1:0]);
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      defCyl_reg <= 16'h0000;
    end else if (wrCtl && address == `IDB_OFF_DEFCYL) begin
      defCyl_reg <= mrg16(defCyl_reg, wd[15:0], be[1:0]);
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      defHead_reg <= 16'h0000;
    end else if (wrCtl && address == `IDB_OFF_DEFHEAD) begin
      defHead_reg <= mrg16(defHead_reg, wd[15:0], be[1:0]);
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      defSpt_reg <= 16'h0000;
    end else if (wrCtl && address == `IDB_OFF_DEFSPT) begin
      defSpt_reg <= mrg16(defSpt_reg, wd[15:0], be[1:0]);
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      totalSect_reg <= 32'h00000000;
    end else if (wrCtl && address == `IDB_OFF_TOTAL) begin
      totalSect_reg <= mrg(totalSect_reg, wd, be);
    end
  end

  // ------------------------------------------------------------------
  // current geometry
  // ------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      curCyl_reg <= 16'h0000;
    end else if (wrCtl && address == `IDB_OFF_CURCYL) begin
      curCyl_reg <= mrg16(curCyl_reg, wd[15:0], be[1:0]);
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      curHead_reg <= 16'h0000;
    end else if (wrCtl && address == `IDB_OFF_CURHEAD) begin
      curHead_reg <= mrg16(curHead_reg, wd[15:0], be[1:0]);
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      curSpt_reg <= 16'h0000;
    end else if (wrCtl && address == `IDB_OFF_CURSPT) begin
      curSpt_reg <= mrg16(curSpt_reg, wd[15:0], be[1:0]);
    end
  end

  // ------------------------------------------------------------------
  // multiple-sector limits
  // ------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      multMax_reg   <= 8'h00;
      multCur_reg   <= 8'h00;
      multValid_reg <= 1'b0;
    end else if (wrCtl && address == `IDB_OFF_MULT) begin
      if (be[0]) multMax_reg <= wd[7:0];
      if (be[1]) multCur_reg <= wd[15:8];
      if (be[2]) multValid_reg <= wd[16];
    end
  end

  // ------------------------------------------------------------------
  // capability and transfer mode settings
  // ------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      standby_reg   <= 1'b0;
      iordy_reg     <= 1'b0;
      iordyOff_reg  <= 1'b0;
      geomValid_reg <= 1'b0;
      extValid_reg  <= 1'b0;
    end else if (wrCtl && address == `IDB_OFF_CAPS && be[0]) begin
      standby_reg   <= wd[0];
      iordy_reg     <= wd[1];
      iordyOff_reg  <= wd[2];
      geomValid_reg <= wd[3];
      extValid_reg  <= wd[4];
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      pioBasic_reg <= 2'h0;
      pioAdv_reg   <= 2'h0;
      dmaSup_reg   <= 8'h00;
      dmaAct_reg   <= 3'h0;
    end else if (wrCtl && address == `IDB_OFF_XFER) begin
      if (be[0]) pioBasic_reg <= wd[1:0];
      if (be[1]) pioAdv_reg <= wd[9:8];
      if (be[2]) dmaSup_reg <= wd[23:16];
      if (be[3]) dmaAct_reg <= wd[26:24];
    end
  end

  // vendor byte count, reset to the plain long length
  always @(posedge clk) begin
    if (srst) begin
      longCnt_reg <= `IDB_RST_LONG;
    end else if (wrCtl && address == `IDB_OFF_LONG) begin
      longCnt_reg <= mrg16(longCnt_reg, wd[15:0], be[1:0]);
    end
  end

  // ------------------------------------------------------------------
  // string store, reset to spaces so short strings stay padded
  // ------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      for (i = 0; i < `IDB_STR_WORDS; i = i + 1) begin
        strMem[i] <= `IDB_SPACES;
      end
    end else if (write & strSel) begin
      if (be[0]) strMem[address[7:2]][7:0]  <= wd[7:0];
      if (be[1]) strMem[address[7:2]][15:8] <= wd[15:8];
    end
  end

endmodule

// File: sim/idb_identify_chk.sv
`timescale 1ns/1ps
module idb_identify_chk #(
  parameter ADDR_W = 11
) (
  input wire              clk,
  input wire              srst,
  input wire [ADDR_W-1:0] address,
  input wire              read,
  input wire              write,
  input wire [3:0]        byteenable,
  input wire [31:0]       writedata,
  input wire [31:0]       readdata,
  input wire              waitrequest
);
  reg  [7:0]  max_reg;
  reg  [31:0] tot_reg;
  wire        idRd = read && !waitrequest && address[10];
  wire [7:0]  wn   = address[9:2];
  wire        big  = tot_reg > 32'h00FC0000;
  // ----------------------------------------
  // shadow of the limits the image follows
  // ----------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      max_reg <= 8'h00;
      tot_reg <= 32'h00000000;
    end else if (write && byteenable == 4'hF) begin
      if (address == 11'h020) max_reg <= writedata[7:0];
      if (address == 11'h010) tot_reg <= writedata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  AST_WR_NOWAIT: assert property (write |-> !waitrequest)
    else $error("write was stalled");
  AST_RD_ONEWAIT: assert property ($rose(read) |-> waitrequest ##1 !waitrequest)
    else $error("read wait state count wrong");
  AST_CFG_TOP: assert property (idRd && wn == 8'h00 |-> !readdata[15])
    else $error("word 0 bit 15 set");
  AST_BIG_CYL: assert property (idRd && wn == 8'h01 && big |-> readdata == 32'h3FFF)
    else $error("large capacity cylinders wrong");
  AST_BIG_SPT: assert property (idRd && wn == 8'h06 && big |-> readdata == 32'h3F)
    else $error("large capacity sectors wrong");
  AST_MULT_MAX: assert property (idRd && wn == 8'h2F |-> readdata == {24'h0, max_reg})
    else $error("block limit word wrong");
  AST_MSET_ZERO: assert property (idRd && wn == 8'h3B && max_reg == 8'h00 |-> readdata[8:0] == 9'h000)
    else $error("block setting not zero");
  AST_TOTAL: assert property (idRd && wn == 8'h3C |-> readdata[15:0] == tot_reg[15:0])
    else $error("total sectors wrong");
  AST_DMA_HOT: assert property (idRd && wn == 8'h3F |-> $onehot(readdata[15:8]))
    else $error("active dma mode not one-hot");
  AST_RSV: assert property (idRd && (wn > 8'h40 || wn == 8'h02 || wn == 8'h30) |-> readdata == 32'h0)
    else $error("reserved word not zero");
endmodule
bind idb_identify_block idb_identify_chk #(.ADDR_W(ADDR_W)) idb_identify_chk_inst (
  .clk(clk), .srst(srst), .address(address), .read(read), .write(write),
  .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest));

// File: sim/idb_host_model.sv
`timescale 1ns/1ps
module idb_host_model (
  input  wire        clk,
  output reg  [10:0] address,
  output reg         read,
  output reg         write,
  output reg  [3:0]  byteenable,
  output reg  [31:0] writedata,
  input  wire [31:0] readdata,
  input  wire        waitrequest,
  output reg         hang
);
  initial begin
    address = 11'h7FC;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'h0;
    writedata = 32'h00000000;
    hang = 1'b0;
  end
  // ----------------------------------------
  // one bus cycle, held until accepted or for at most 20 wait cycles, then hang is set
  // ----------------------------------------
  task bus_xfer(input isWr, input [10:0] a, input [31:0] d, output [31:0] q);
    integer n;
    begin
      @(posedge clk);
      address <= a;
      writedata <= d;
      byteenable <= 4'hF;
      read <= !isWr;
      write <= isWr;
      n = 0;
      @(posedge clk);
      while (waitrequest && n < 20) begin
        n = n + 1;
        @(posedge clk);
      end
      if (waitrequest) hang <= 1'b1;
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      // released lines do not keep the last value
      address <= ~a;
      writedata <= ~d;
      byteenable <= 4'h0;
    end
  endtask
endmodule

// File: sim/idb_identify_block_bench.sv
`timescale 1ns/1ps
`include "idb_consts.vh"
module idb_identify_block_bench;
  reg         clk;
  reg         srst;
  wire [10:0] address;
  wire        read;
  wire        write;
  wire [3:0]  byteenable;
  wire [31:0] writedata;
  wire [31:0] readdata;
  wire        waitrequest;
  wire        hang;
  integer     n_mismatch;
  integer     n_tests;
  integer     i;
  reg  [31:0] q;
  reg  [31:0] cap;
  reg  [71:0] row;
  idb_identify_block idb_identify_block_inst (
    .clk(clk), .srst(srst), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest));
  idb_host_model idb_host_model_inst (
    .clk(clk), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .hang(hang));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task final_report;
    begin
      $display("mismatches %0d of %0d comparisons", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  always @(posedge hang) begin
    n_mismatch = n_mismatch + 1;
    final_report;
  end
  task chk(input string name, input [31:0] exp, input [31:0] got);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
    end
  endtask
  task wr(input [10:0] a, input [31:0] d);
    idb_host_model_inst.bus_xfer(1'b1, a, d, q);
  endtask
  task idw(input [7:0] w, input [15:0] e);
    begin
      idb_host_model_inst.bus_xfer(1'b0, {1'b1, w, 2'b00}, 32'h0, q);
      chk($sformatf("word %0d", w), {16'h0000, e}, q);
    end
  endtask
  // ----------------------------------------
  // rows: register, value, word, expected
  // ----------------------------------------
  function [71:0] trow(input integer k);
    case (k)
      0: trow = {`IDB_OFF_CAPS, 5'h0, 32'h01, 8'h31, 16'h2000};
      1: trow = {`IDB_OFF_CAPS, 5'h0, 32'h02, 8'h31, 16'h0800};
      2: trow = {`IDB_OFF_CAPS, 5'h0, 32'h04, 8'h31, 16'h0400};
      3: trow = {`IDB_OFF_CAPS, 5'h0, 32'h08, 8'h35, 16'h0001};
      4: trow = {`IDB_OFF_CAPS, 5'h0, 32'h10, 8'h35, 16'h0002};
      5: trow = {`IDB_OFF_CAPS, 5'h0, 32'h00, 8'h31, 16'h0000};
      6: trow = {`IDB_OFF_XFER, 5'h0, 32'h02, 8'h33, 16'h0200};
      7: trow = {`IDB_OFF_XFER, 5'h0, 32'h03, 8'h33, 16'h0000};
      8: trow = {`IDB_OFF_XFER, 5'h0, 32'h100, 8'h40, 16'h0001};
      9: trow = {`IDB_OFF_XFER, 5'h0, 32'h100, 8'h31, 16'h0800};
      10: trow = {`IDB_OFF_XFER, 5'h0, 32'h100, 8'h35, 16'h0002};
      11: trow = {`IDB_OFF_XFER, 5'h0, 32'h200, 8'h40, 16'h0002};
      12: trow = {`IDB_OFF_XFER, 5'h0, 32'h01020000, 8'h3F, 16'h0202};
      13: trow = {`IDB_OFF_XFER, 5'h0, 32'h01020000, 8'h35, 16'h0002};
      14: trow = {`IDB_OFF_XFER, 5'h0, 32'h00010000, 8'h35, 16'h0000};
      default: trow = {`IDB_OFF_XFER, 5'h0, 32'h00010000, 8'h3F, 16'h0101};
    endcase
  endfunction
  initial begin
    srst = 1'b1;
    n_mismatch = 0;
    n_tests = 0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    idw(8'h16, 16'h0004);
    idw(8'h13, 16'h2020);
    wr(`IDB_OFF_CFG, 32'h0000FFFF);
    idw(8'h00, 16'h7FFF);
    wr(`IDB_OFF_DEFCYL, 32'h03E8);
    wr(`IDB_OFF_DEFHEAD, 32'h000F);
    wr(`IDB_OFF_DEFSPT, 32'h0011);
    for (i = 0; i < 2; i = i + 1) begin
      wr(`IDB_OFF_TOTAL, 32'h00FC0000 + i);
      idw(8'h01, (i != 0) ? 16'h3FFF : 16'h03E8);
      idw(8'h03, (i != 0) ? 16'h0010 : 16'h000F);
      idw(8'h06, (i != 0) ? 16'h003F : 16'h0011);
      idw(8'h3C, i[15:0]);
      idw(8'h3D, 16'h00FC);
    end
    wr(`IDB_OFF_CURCYL, 32'h1234);
    wr(`IDB_OFF_CURHEAD, 32'h000F);
    wr(`IDB_OFF_CURSPT, 32'h003F);
    cap = 32'h1234 * 32'h000F * 32'h003F;
    idw(8'h36, 16'h1234);
    idw(8'h37, 16'h000F);
    idw(8'h38, 16'h003F);
    idw(8'h39, cap[15:0]);
    idw(8'h3A, cap[31:16]);
    idw(8'h3C, 16'h0001);
    wr(11'h100, 32'h4142);
    idw(8'h0A, 16'h4142);
    wr(11'h128, 32'h0000);
    idw(8'h17, 16'h0000);
    wr(11'h12C, 32'h312E);
    idw(8'h18, 16'h312E);
    idw(8'h1A, 16'h2020);
    wr(11'h138, 32'h5859);
    idw(8'h1B, 16'h5859);
    idw(8'h2E, 16'h2020);
    wr(`IDB_OFF_MULT, 32'h00010810);
    idw(8'h2F, 16'h0010);
    idw(8'h3B, 16'h0108);
    wr(`IDB_OFF_MULT, 32'h00010800);
    idw(8'h3B, 16'h0000);
    for (i = 0; i < 16; i = i + 1) begin
      row = trow(i);
      wr(row[71:61], row[55:24]);
      idw(row[23:16], row[15:0]);
    end
    idw(8'h02, 16'h0000);
    idw(8'h30, 16'h0000);
    idw(8'h41, 16'h0000);
    idw(8'hFF, 16'h0000);
    idb_host_model_inst.bus_xfer(1'b0, 11'h0F0, 32'h0, q);
    chk("unmapped read", 32'h0, q);
    wr(11'h404, 32'h0000FFFF);
    idw(8'h01, 16'h3FFF);
    wr(`IDB_OFF_LONG, 32'h0008);
    idw(8'h16, 16'h0008);
    idb_host_model_inst.bus_xfer(1'b0, `IDB_OFF_STAT, 32'h0, q);
    chk("long count flag", 32'h1, {31'h0, q[3]});
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    idw(8'h00, 16'h0000);
    idw(8'h16, 16'h0004);
    idw(8'h0A, 16'h2020);
    final_report;
  end
endmodule
